// *** common/sfr_pkg.sv ***
// Constants for the safety flag summary and voltage reaction register bank
package sfr_pkg;
  localparam int ADDR_W = 4;
  localparam int GRP_W  = 4;
  localparam int VOLT_W = 12;
  localparam int MON_W  = 6;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_SUMMARY = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CFG     = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_MASK    = 4'hc;

  // Group flag positions, shared by summary, event status and mask
  localparam int POS_COMM    = 23;
  localparam int POS_REFRESH = 22;
  localparam int POS_PIN     = 21;
  localparam int POS_VOLT    = 20;

  // Configuration field positions (lsb of each field)
  localparam int POS_CORE_OVER  = 22;
  localparam int POS_CORE_UNDER = 20;
  localparam int POS_IO_OVER    = 10;
  localparam int POS_IO_UNDER   = 8;
  localparam int POS_SEL_CORE   = 18;
  localparam int POS_SEL_IO     = 17;
  localparam int POS_SEL_AUX1   = 16;
  localparam int POS_SEL_AUX2   = 15;
  localparam int POS_SEL_AUX3   = 14;
  localparam int POS_SEL_AUX4   = 13;

  // Index of each monitor in the self-test vectors
  localparam int MON_AUX4 = 0;
  localparam int MON_AUX3 = 1;
  localparam int MON_AUX2 = 2;
  localparam int MON_AUX1 = 3;
  localparam int MON_IO   = 4;
  localparam int MON_CORE = 5;

  // Reset values and writable bits
  localparam logic [31:0]      CFG_RESET    = 32'h00d00d00;
  localparam logic [31:0]      CFG_WMASK    = 32'h00f7ef00;
  localparam logic [GRP_W-1:0] STATUS_RESET = 4'h0;
  localparam logic [GRP_W-1:0] MASK_RESET   = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sfr_pkg

// *** logic/sfr_axil_slave.sv ***
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
`default_nettype none
module sfr_axil_slave (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Write address and data
  input  wire logic [sfr_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // Write response
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // Read address and data
  input  wire logic [sfr_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Register side
  output logic                            wrEn,
  output logic [sfr_pkg::ADDR_W-1:0]      wrAddr,
  output logic [31:0]                     wrData,
  output logic [3:0]                      wrStrb,
  input  wire logic                       wrErr,
  output logic                            rdEn,
  output logic [sfr_pkg::ADDR_W-1:0]      rdAddr,
  input  wire logic [31:0]                rdData,
  input  wire logic                       rdErr
);
  import sfr_pkg::*;

  typedef struct packed {
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wHeld;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
  } sfr_axil_t;

  sfr_axil_t s;
  sfr_axil_t next_s;

  // Holding each half until the pair is complete lets address and data arrive in any order
  assign awready = !s.awHeld && !s.bValid;
  assign wready  = !s.wHeld && !s.bValid;
  assign wrEn    = s.awHeld && s.wHeld && !s.bValid;
  assign wrAddr  = s.awAddr;
  assign wrData  = s.wData;
  assign wrStrb  = s.wStrb;
  assign bvalid  = s.bValid;
  assign bresp   = s.bResp;
  assign arready = !s.rValid;
  assign rdEn    = arvalid && !s.rValid;
  assign rdAddr  = araddr;
  assign rvalid  = s.rValid;
  assign rdata   = s.rData;
  assign rresp   = s.rResp;

  always_comb begin
    next_s = s;
    if (awvalid && awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (wrEn) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = wrErr ? RESP_SLVERR : RESP_OKAY;
    end else if (s.bValid && bready) begin
      next_s.bValid = 1'b0;
    end
    if (rdEn) begin
      next_s.rValid = 1'b1;
      next_s.rData  = rdData;
      next_s.rResp  = rdErr ? RESP_SLVERR : RESP_OKAY;
    end else if (s.rValid && rready) begin
      next_s.rValid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : sfr_axil_slave
`default_nettype wire

// *** logic/sfr_regs.sv ***
// Safety flag summary, monitor self-test select and reaction register bank
// What this block does
// - Communication group flag is OR of three serial and two two-wire errors.
// - Refresh group flag is OR of refresh data and timing errors.
// - Safety-pin group flag is OR of power-good, reset and fail-safe pin diagnostics.
// - Voltage group flag is OR of twelve core, IO and auxiliary OV/UV flags.
// - Group flags are live, unlatched; they drop once all contributors clear.
// - Core monitor self-test select bit runs its test in phase two; resets 0.
// - IO supply monitor self-test select bit runs its test in phase two; resets 0.
// - Auxiliary one to three select bits run their tests in phase two; reset 0.
// - Auxiliary four select bit runs its test in phase two; resets 0.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sfr_regs (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // AXI4-Lite write
  input  wire logic [sfr_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read
  input  wire logic [sfr_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Detailed communication flags
  input  wire logic                       serialClockError,
  input  wire logic                       serialRequestError,
  input  wire logic                       serialCrcError,
  input  wire logic                       twowireCrcError,
  input  wire logic                       twowireRequestError,
  // Detailed refresh flags
  input  wire logic                       refreshDataError,
  input  wire logic                       refreshTimingError,
  // Detailed pin diagnostics
  input  wire logic                       powerGoodPinDiag,
  input  wire logic                       resetPinDiag,
  input  wire logic                       failsafeOutPinDiag,
  // Detailed monitor flags, core OV at bit 11 down to aux1 UV at bit 0
  input  wire logic [sfr_pkg::VOLT_W-1:0] voltMonFlags,
  // Self-test sequencer
  input  wire logic                       analogSelftestPhaseTwo,
  // Group flags
  output logic                            commGroupFlag,
  output logic                            refreshGroupFlag,
  output logic                            safetyPinGroupFlag,
  output logic                            voltageGroupFlag,
  // Monitor self-test selection and run enables
  output logic [sfr_pkg::MON_W-1:0]       selftestSel,
  output logic [sfr_pkg::MON_W-1:0]       selftestRun,
  // Fault reaction fields
  output logic [1:0]                      coreOverReaction,
  output logic [1:0]                      coreUnderReaction,
  output logic [1:0]                      ioOverReaction,
  output logic [1:0]                      ioUnderReaction,
  // Interrupt
  output logic                            irq
);
  import sfr_pkg::*;

  typedef struct packed {
    logic [31:0]      cfg;
    logic [GRP_W-1:0] status;
    logic [GRP_W-1:0] mask;
    logic [GRP_W-1:0] prevGroup;
    logic [MON_W-1:0] run;
  } sfr_state_t;

  sfr_state_t s;
  sfr_state_t next_s;

  logic                  wrEn;
  logic [ADDR_W-1:0]     wrAddr;
  logic [31:0]           wrData;
  logic [3:0]            wrStrb;
  logic                  wrErr;
  logic                  rdEn;
  logic [ADDR_W-1:0]     rdAddr;
  logic [31:0]           rdData;
  logic                  rdErr;
  logic [GRP_W-1:0]      groups;
  logic [GRP_W-1:0]      statusClr;
  logic [31:0]           byteMask;
  logic [31:0]           groupWord;

  sfr_axil_slave u_bus (
    .ref_clk (ref_clk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wrEn    (wrEn),
    .wrAddr  (wrAddr),
    .wrData  (wrData),
    .wrStrb  (wrStrb),
    .wrErr   (wrErr),
    .rdEn    (rdEn),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .rdErr   (rdErr)
  );

  // Pure gates on the detailed flags, so the summary can never disagree with them
  assign commGroupFlag = serialClockError | serialRequestError | serialCrcError
                       | twowireCrcError | twowireRequestError;
  assign refreshGroupFlag   = refreshDataError | refreshTimingError;
  assign safetyPinGroupFlag = powerGoodPinDiag | resetPinDiag
                            | failsafeOutPinDiag;
  assign voltageGroupFlag   = |voltMonFlags;

  assign groups = {commGroupFlag, refreshGroupFlag, safetyPinGroupFlag, voltageGroupFlag};
  assign groupWord = 32'(groups) << POS_VOLT;

  assign selftestSel       = s.cfg[POS_SEL_AUX4 +: MON_W];
  assign selftestRun       = s.run;
  assign coreOverReaction  = s.cfg[POS_CORE_OVER +: 2];
  assign coreUnderReaction = s.cfg[POS_CORE_UNDER +: 2];
  assign ioOverReaction    = s.cfg[POS_IO_OVER +: 2];
  assign ioUnderReaction   = s.cfg[POS_IO_UNDER +: 2];
  assign irq               = |(s.status & s.mask);

  // Address decode for both directions
  always_comb begin
    if (wrAddr == OFF_SUMMARY || wrAddr == OFF_CFG
        || wrAddr == OFF_STATUS || wrAddr == OFF_MASK) begin
      wrErr = 1'b0;
    end else begin
      wrErr = 1'b1;
    end
    rdErr = 1'b0;
    if (rdAddr == OFF_SUMMARY) begin
      rdData = groupWord;
    end else if (rdAddr == OFF_CFG) begin
      rdData = s.cfg & CFG_WMASK;
    end else if (rdAddr == OFF_STATUS) begin
      rdData = 32'(s.status) << POS_VOLT;
    end else if (rdAddr == OFF_MASK) begin
      rdData = 32'(s.mask) << POS_VOLT;
    end else begin
      rdData = 32'h00000000;
      rdErr  = 1'b1;
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byteMask[8*b +: 8] = {8{wrStrb[b]}};
    end
    statusClr = '0;
    next_s    = s;
    next_s.prevGroup = groups;
    // Reserved bits are dropped on write, whatever software sends
    if (wrEn && wrAddr == OFF_CFG) begin
      next_s.cfg = (s.cfg & ~(byteMask & CFG_WMASK))
                 | (wrData & byteMask & CFG_WMASK);
    end
    if (wrEn && wrAddr == OFF_MASK) begin
      next_s.mask = (s.mask & ~byteMask[POS_VOLT +: GRP_W])
                  | (wrData[POS_VOLT +: GRP_W] & byteMask[POS_VOLT +: GRP_W]);
    end
    if (wrEn && wrAddr == OFF_STATUS) begin
      statusClr = wrData[POS_VOLT +: GRP_W] & byteMask[POS_VOLT +: GRP_W];
    end
    // A rising group flag in the clearing cycle still lands
    next_s.status = (s.status & ~statusClr) | (groups & ~s.prevGroup);
    // Run enables follow the phase, gated by the select bits
    next_s.run = analogSelftestPhaseTwo ? next_s.cfg[POS_SEL_AUX4 +: MON_W]
                                        : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s.cfg       <= CFG_RESET;
      s.status    <= STATUS_RESET;
      s.mask      <= MASK_RESET;
      s.prevGroup <= '0;
      s.run       <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Checks on the group flags
  chk_comm_or: assert property (@(posedge ref_clk) disable iff (rst)
    commGroupFlag == (serialClockError || serialRequestError || serialCrcError
                      || twowireCrcError || twowireRequestError))
    else $error("comm group flag differs from its detailed flags");

  chk_refresh_or: assert property (@(posedge ref_clk) disable iff (rst)
    refreshGroupFlag == (refreshDataError || refreshTimingError))
    else $error("refresh group flag differs from its detailed flags");

  chk_pin_or: assert property (@(posedge ref_clk) disable iff (rst)
    safetyPinGroupFlag == (powerGoodPinDiag || resetPinDiag || failsafeOutPinDiag))
    else $error("safety pin group flag differs from its diagnostics");

  chk_volt_or: assert property (@(posedge ref_clk) disable iff (rst)
    voltageGroupFlag == (voltMonFlags != 12'h000))
    else $error("voltage group flag differs from monitor flags");

  chk_summary_live: assert property (@(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr == OFF_SUMMARY
    |=> rvalid && rdata == (32'($past(groups)) << POS_VOLT))
    else $error("summary read is not the live group flags");

  chk_group_drop: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(voltageGroupFlag) && !$past(rst) |-> voltMonFlags == 12'h000)
    else $error("voltage group flag fell with a flag still set");

  // Checks on self-test selection
  chk_core_run: assert property (@(posedge ref_clk) disable iff (rst)
    analogSelftestPhaseTwo && selftestSel[MON_CORE] && !wrEn
    |=> selftestRun[MON_CORE])
    else $error("core monitor test not run in phase two");

  chk_io_run: assert property (@(posedge ref_clk) disable iff (rst)
    !selftestSel[MON_IO] && !wrEn |=> !selftestRun[MON_IO])
    else $error("io monitor test ran while deselected");

  chk_aux_run: assert property (@(posedge ref_clk) disable iff (rst)
    !analogSelftestPhaseTwo |=> selftestRun[MON_AUX1 -: 3] == 3'h0)
    else $error("auxiliary monitor test ran outside phase two");

  chk_sel_reset: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> selftestSel == 6'h00 && selftestRun == 6'h00)
    else $error("self-test selects not cleared by reset");

  chk_aux4_run: assert property (@(posedge ref_clk) disable iff (rst)
    analogSelftestPhaseTwo && selftestSel[MON_AUX4] && !wrEn
    |=> selftestRun[MON_AUX4])
    else $error("aux4 monitor test not run in phase two");

  // Checks on the configuration register
  chk_cfg_write: assert property (@(posedge ref_clk) disable iff (rst)
    wrEn && wrAddr == OFF_CFG && wrStrb == 4'hf
    |=> coreOverReaction == $past(wrData[POS_CORE_OVER +: 2])
        && ioUnderReaction == $past(wrData[POS_IO_UNDER +: 2])
        && bvalid && bresp == RESP_OKAY)
    else $error("reaction fields not taken from a full write");

  chk_cfg_reserved: assert property (@(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr == OFF_CFG |=> (rdata & ~CFG_WMASK) == 32'h00000000)
    else $error("reserved configuration bits read non-zero");

  // Checks on the bus and interrupt
  chk_unmapped_err: assert property (@(posedge ref_clk) disable iff (rst)
    rdEn && rdAddr != OFF_SUMMARY && rdAddr != OFF_CFG && rdAddr != OFF_STATUS
    && rdAddr != OFF_MASK |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h00000000)
    else $error("unmapped read not answered with an error");

  chk_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(voltageGroupFlag) && s.mask[0] |=> irq)
    else $error("masked-in event did not raise the interrupt");
endmodule : sfr_regs
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the safety flag summary and reaction register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfr_pkg::*;

  logic              ref_clk, rst;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [21:0]       det;
  logic              phaseTwo, irq;
  logic              commGroupFlag, refreshGroupFlag, safetyPinGroupFlag, voltageGroupFlag;
  logic [MON_W-1:0]  selftestSel, selftestRun;
  logic [1:0]        coreOverReaction, coreUnderReaction, ioOverReaction, ioUnderReaction;
  int                failCount, checked;

  sfr_regs sfr_regs_i (
    .ref_clk(ref_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serialClockError(det[21]), .serialRequestError(det[20]), .serialCrcError(det[19]),
    .twowireCrcError(det[18]), .twowireRequestError(det[17]),
    .refreshDataError(det[16]), .refreshTimingError(det[15]),
    .powerGoodPinDiag(det[14]), .resetPinDiag(det[13]), .failsafeOutPinDiag(det[12]),
    .voltMonFlags(det[11:0]), .analogSelftestPhaseTwo(phaseTwo),
    .commGroupFlag(commGroupFlag), .refreshGroupFlag(refreshGroupFlag),
    .safetyPinGroupFlag(safetyPinGroupFlag), .voltageGroupFlag(voltageGroupFlag),
    .selftestSel(selftestSel), .selftestRun(selftestRun),
    .coreOverReaction(coreOverReaction), .coreUnderReaction(coreUnderReaction),
    .ioOverReaction(ioOverReaction), .ioUnderReaction(ioUnderReaction),
    .irq(irq)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic report_and_stop;
    if (failCount == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Expected group flags, worked out from the detailed flag vector
  function automatic logic [3:0] groups(input logic [21:0] d);
    return {|d[21:17], |d[16:15], |d[14:12], |d[11:0]};
  endfunction : groups

  // Both halves offered together; each released on its own handshake
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] expR,
                    input string what);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    wvalid  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(32'(bresp), 32'(expR), what);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] expD, input logic [1:0] expR,
                    input string what);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check(rdata, expD, what);
    check(32'(rresp), 32'(expR), what);
  endtask : rd

  initial begin
    repeat (20000) @(posedge ref_clk);
    failCount++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1; awaddr = '0; awvalid = 1'b0; wdata = '0; wstrb = '0; wvalid = 1'b0;
    // Response ready stays high, so back-to-back calls never drive it twice in one step
    bready = 1'b1; araddr = '0; arvalid = 1'b0; rready = 1'b1; det = '0; phaseTwo = 1'b0;
    failCount = 0; checked = 0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    // Reset state of the bank
    @(negedge ref_clk);
    check(32'({coreOverReaction, coreUnderReaction, ioOverReaction, ioUnderReaction}),
          32'h000000dd, "reaction reset");
    check(32'(selftestSel), 32'h0, "select reset");
    check(32'(irq), 32'h0, "irq reset");
    @(posedge ref_clk);
    rd(OFF_CFG, CFG_RESET, RESP_OKAY, "cfg reset");
    rd(OFF_SUMMARY, 32'h0, RESP_OKAY, "summary idle");
    rd(OFF_MASK, 32'h0, RESP_OKAY, "mask reset");
    // Each detailed flag alone must raise exactly its own group
    for (int i = 0; i < 22; i++) begin
      det <= 22'h1 << i;
      @(negedge ref_clk);
      check(32'({commGroupFlag, refreshGroupFlag, safetyPinGroupFlag, voltageGroupFlag}),
            32'(groups(22'h1 << i)), "group flags");
      check(32'(irq), 32'h0, "irq with mask clear");
      @(posedge ref_clk);
    end
    // Live flag holds while any contributor remains, drops with the last one
    det <= 22'h000801;
    @(posedge ref_clk);
    rd(OFF_SUMMARY, 32'h00100000, RESP_OKAY, "summary two faults");
    det <= 22'h000001;
    rd(OFF_SUMMARY, 32'h00100000, RESP_OKAY, "summary one fault");
    det <= 22'h200000;
    rd(OFF_SUMMARY, 32'h00800000, RESP_OKAY, "summary comm only");
    det <= '0;
    @(negedge ref_clk);
    check(32'({commGroupFlag, voltageGroupFlag}), 32'h0, "flags drop");
    @(posedge ref_clk);
    wr(OFF_SUMMARY, 32'hffffffff, RESP_OKAY, "summary write");
    rd(OFF_SUMMARY, 32'h0, RESP_OKAY, "summary unchanged");
    // Writable fields and reserved bits
    wr(OFF_CFG, 32'hffffffff, RESP_OKAY, "cfg all ones");
    rd(OFF_CFG, CFG_WMASK, RESP_OKAY, "cfg reserved zero");
    @(negedge ref_clk);
    check(32'({coreOverReaction, coreUnderReaction, ioOverReaction, ioUnderReaction,
               selftestSel}), 32'h3fff, "fields all ones");
    @(posedge ref_clk);
    wr(OFF_CFG, 32'h00900400, RESP_OKAY, "cfg pattern");
    @(negedge ref_clk);
    check(32'({coreOverReaction, coreUnderReaction, ioOverReaction, ioUnderReaction}),
          32'h00000094, "reaction pattern");
    // Phase two with no monitor selected runs nothing
    @(posedge ref_clk);
    phaseTwo <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check(32'(selftestRun), 32'h0, "run none selected");
    @(posedge ref_clk);
    phaseTwo <= 1'b0;
    @(posedge ref_clk);
    // One monitor selected at a time, aux4 first up to core
    for (int m = 0; m < MON_W; m++) begin
      wr(OFF_CFG, 32'h1 << (13 + m), RESP_OKAY, "select one");
      phaseTwo <= 1'b1;
      @(negedge ref_clk);
      check(32'(selftestSel), 32'h1 << m, "select bit");
      @(posedge ref_clk);
      @(negedge ref_clk);
      check(32'(selftestRun), 32'h1 << m, "run in phase two");
      @(posedge ref_clk);
      phaseTwo <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
      check(32'(selftestRun), 32'h0, "run outside phase");
      @(posedge ref_clk);
    end
    // Interrupt: raise, mask, clear
    wr(OFF_STATUS, 32'h00f00000, RESP_OKAY, "status clear");
    rd(OFF_STATUS, 32'h0, RESP_OKAY, "status empty");
    wr(OFF_MASK, 32'h00400000, RESP_OKAY, "mask refresh");
    det <= 22'h210000;
    @(posedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check(32'(irq), 32'h1, "irq raised");
    @(posedge ref_clk);
    rd(OFF_STATUS, 32'h00c00000, RESP_OKAY, "status events");
    det <= '0;
    wr(OFF_STATUS, 32'h00400000, RESP_OKAY, "status clear refresh");
    rd(OFF_STATUS, 32'h00800000, RESP_OKAY, "status comm left");
    @(negedge ref_clk);
    check(32'(irq), 32'h0, "irq cleared, comm masked");
    @(posedge ref_clk);
    // Voltage event with its mask bit set drives the interrupt
    wr(OFF_MASK, 32'h00100000, RESP_OKAY, "mask voltage");
    det <= 22'h000400;
    @(posedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    check(32'(irq), 32'h1, "irq voltage");
    @(posedge ref_clk);
    rd(OFF_STATUS, 32'h00900000, RESP_OKAY, "status voltage");
    det <= '0;
    // Unmapped address
    wr(4'h6, 32'hffffffff, RESP_SLVERR, "unmapped write");
    rd(4'h6, 32'h0, RESP_SLVERR, "unmapped read");
    rd(OFF_CFG, 32'h00000000 | (32'h1 << 18), RESP_OKAY, "cfg after unmapped");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
